// ==== hdl/cic_core_interrupt_controller.v ====
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "cic_defines.vh"
// Operation
// RULE1 - maskable hardware requests plus non-maskable trap
// RULE2 - maskable served only with mask clear
// RULE3 - reset sets global mask bit
// RULE4 - entry waits for current instruction end
// RULE5 - push program counter, index, accumulator, condition code
// RULE6 - entry sets the global mask bit
// RULE7 - load program counter with selected vector
// RULE8 - return restores registers, mask becomes clear; the code takes the mask bit from the popped condition code instead
// RULE9 - fixed priority among simultaneous requests
// RULE10 - any wakes wait, selected wake halt
// RULE11 - trap enters regardless of mask
// RULE12 - external vector needs event and clear mask
// RULE13 - software picks external sensitivity and polarity
// RULE14 - edge latch cleared on handler entry
// RULE15 - low configured pin blocks combined source
// RULE16 - peripheral needs mask clear and enable
// RULE17 - flag cleared by zero write or sequence
// RULE18 - clearing sequence drops the pending latch
// RULE19 - halt instruction clears the global mask
module cic_core_interrupt_controller #(
	parameter NPER = 4,
	parameter NPIN = 4,
	parameter [NPER-1:0] HALT_PER_MASK = 0
) (
	// clock and reset
	input wire clk_sys_i,
	input wire srst_i,
	// core handshake, same clock
	input wire cpu_instr_done_i,
	input wire cpu_trap_i,
	input wire cpu_handler_return_instruction_i,
	input wire cpu_halt_exec_i,
	input wire cpu_wait_i,
	input wire cpu_halt_i,
	input wire [7:0] cpu_pop_cc_i,
	// request sources
	input wire [NPER-1:0] periph_flag_i,
	input wire [NPIN-1:0] nand_pins_i,
	input wire external_request_source_i,
	// core control outputs
	output reg stack_push_o,
	output reg stack_pop_o,
	output reg [1:0] stack_sel_o,
	output reg vector_load_o,
	output reg [15:0] vector_addr_o,
	output reg wake_o,
	output reg mask_o,
	output reg irq_o,
	// axi4-lite write channels
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read channels
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
// fsm states
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_PUSH = 2'h1;
localparam [1:0] ST_VEC = 2'h2;
localparam [1:0] ST_POP = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// functions
// edge detection for one external source by its sensitivity code
function edge_hit;
	input [1:0] cfg;
	input cur;
	input prev;
	case (cfg)
		`CIC_SENS_RISE: edge_hit = cur & ~prev;
		`CIC_SENS_FALL: edge_hit = ~cur & prev;
		`CIC_SENS_BOTH: edge_hit = cur ^ prev;
		default: edge_hit = 1'b0;
	endcase
endfunction
// lowest set index wins: trap, ext0, ext1, then peripherals
function [3:0] pick;
	input [7:0] v;
	integer k;
	begin
		pick = 4'h0;
		for (k = 7; k >= 0; k = k - 1) begin
			if (v[k]) begin
				pick = k[3:0];
			end
		end
	end
endfunction
////////////////////////////////////////////////////////////////////////////////
// state
reg [NPIN:0] meta_reg; // first synchroniser stage
reg [NPIN:0] sync_reg; // second synchroniser stage
reg [1:0] src_prev_reg; // previous external levels
reg [1:0] ext_latch_reg; // edge latches
reg [7:0] cc_reg; // condition_code_reg
reg [NPER-1:0] enable_reg; // peripheral enables
reg [3:0] extcfg_reg; // two sensitivity bits per external source
reg [NPIN-1:0] pinsel_reg; // pins configured for the combined source
reg [NPER-1:0] flag_reg; // peripheral request latches
reg [NPER-1:0] armed_reg; // flags seen set by a status read
reg trap_reg; // trap request held until entry
reg [3:0] istat_reg; // sticky events
reg [3:0] imask_reg; // event mask
reg [1:0] state_reg; // sequencer state
reg [1:0] cnt_reg; // push and pop step
reg [3:0] sel_reg; // source chosen for entry
reg [7:0] awaddr_reg; // held write address
reg aw_full_reg; // write address held
reg [7:0] wdata_reg; // held write data, low byte
reg wstrb0_reg; // held lane 0 strobe
reg w_full_reg; // write data held
// combinational terms
wire [1:0] src_lvl; // external source levels
wire [1:0] ext_pend; // external pending
wire [NPER-1:0] per_pend; // peripherals enabled and flagged
wire [7:0] all_pend; // every source, trap at index 0
wire [7:0] mask_pend; // sources allowed by the global mask
wire [7:0] halt_cap; // sources able to leave halt
wire wr_go; // a register write happens now
wire rd_go; // a register read happens now
wire i_bit; // global mask bit
reg [7:0] rd_val; // read mux
reg rd_ok; // read address mapped
reg [3:0] ev; // events this cycle
assign i_bit = cc_reg[`CIC_CC_I_BIT];
// combined source is high only if every configured pin is high [RULE15]
assign src_lvl[0] = &(sync_reg[NPIN-1:0] | ~pinsel_reg);
assign src_lvl[1] = sync_reg[NPIN];
// low level mode follows the pin, edge modes use the latch [RULE13]
assign ext_pend[0] = (extcfg_reg[1:0] == `CIC_SENS_LOW) ? ~src_lvl[0] : ext_latch_reg[0];
assign ext_pend[1] = (extcfg_reg[3:2] == `CIC_SENS_LOW) ? ~src_lvl[1] : ext_latch_reg[1];
// peripheral request needs its enable; flag stays latched regardless [RULE16]
assign per_pend = flag_reg & enable_reg;
assign all_pend = {{(5 - NPER){1'b0}}, per_pend, ext_pend, trap_reg}; // [RULE1]
// maskable ones only while the mask is clear, trap always [RULE2] [RULE11] [RULE12]
assign mask_pend = {all_pend[7:1] & {7{~i_bit}}, all_pend[0]};
assign halt_cap = {{(5 - NPER){1'b0}}, HALT_PER_MASK, 2'h3, 1'b0};
assign wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
assign rd_go = s_axi_arvalid & s_axi_arready;
////////////////////////////////////////////////////////////////////////////////
// read mux
always @* begin
	rd_val = 8'h00;
	rd_ok = 1'b1;
	case (s_axi_araddr)
		`CIC_OFS_CC: rd_val = cc_reg;
		`CIC_OFS_ENABLE: rd_val[NPER-1:0] = enable_reg;
		`CIC_OFS_EXTCFG: rd_val[3:0] = extcfg_reg;
		`CIC_OFS_PINSEL: rd_val[NPIN-1:0] = pinsel_reg;
		`CIC_OFS_PFLAG: rd_val[NPER-1:0] = flag_reg;
		`CIC_OFS_ASSOC: rd_val = 8'h00;
		`CIC_OFS_ISTAT: rd_val[3:0] = istat_reg;
		`CIC_OFS_IMASK: rd_val[3:0] = imask_reg;
		`CIC_OFS_STATE: rd_val = {sel_reg, cnt_reg, state_reg};
		default: rd_ok = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser and edge latches
always @(posedge clk_sys_i) begin
	if (srst_i) begin
		meta_reg <= {(NPIN + 1){1'b1}}; // idle high, no false edge after reset
		sync_reg <= {(NPIN + 1){1'b1}}; // matches the previous-level reset
		src_prev_reg <= 2'h3;
		ext_latch_reg <= 2'h0;
	end else begin
		meta_reg <= {external_request_source_i, nand_pins_i};
		sync_reg <= meta_reg;
		src_prev_reg <= src_lvl;
		// a new edge wins over the entry clear [RULE14]
		ext_latch_reg[0] <= edge_hit(extcfg_reg[1:0], src_lvl[0], src_prev_reg[0])
			| (ext_latch_reg[0] & ~(state_reg == ST_VEC && sel_reg == 4'h1));
		ext_latch_reg[1] <= edge_hit(extcfg_reg[3:2], src_lvl[1], src_prev_reg[1])
			| (ext_latch_reg[1] & ~(state_reg == ST_VEC && sel_reg == 4'h2));
	end
end

////////////////////////////////////////////////////////////////////////////////
// entry and return sequencer
always @(posedge clk_sys_i) begin
	if (srst_i) begin
		state_reg <= ST_IDLE;
		cnt_reg <= 2'h0;
		sel_reg <= 4'h0;
		trap_reg <= 1'b0;
		stack_push_o <= 1'b0;
		stack_pop_o <= 1'b0;
		stack_sel_o <= 2'h0;
		vector_load_o <= 1'b0;
		vector_addr_o <= `CIC_VEC_TOP;
	end else begin
		stack_push_o <= 1'b0;
		stack_pop_o <= 1'b0;
		vector_load_o <= 1'b0;
		// trap held until its entry
		if (cpu_trap_i) begin
			trap_reg <= 1'b1;
		end else if (state_reg == ST_VEC && sel_reg == 4'h0) begin
			trap_reg <= 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				if (cpu_handler_return_instruction_i) begin
					state_reg <= ST_POP;
					cnt_reg <= 2'h0;
				end else if (cpu_instr_done_i && (|mask_pend || cpu_trap_i)) begin
					// start only at an instruction boundary [RULE4]
					state_reg <= ST_PUSH;
					cnt_reg <= 2'h0;
					// fixed order, lowest index first [RULE9]
					sel_reg <= cpu_trap_i ? 4'h0 : pick(mask_pend);
				end
			end
			ST_PUSH: begin
				// pc, x, a, cc in steps 0..3 [RULE5]
				stack_push_o <= 1'b1;
				stack_sel_o <= cnt_reg;
				cnt_reg <= cnt_reg + 2'h1;
				if (cnt_reg == 2'h3) begin
					state_reg <= ST_VEC;
				end
			end
			ST_VEC: begin
				// vector load to fetch the handler [RULE7]
				vector_load_o <= 1'b1;
				vector_addr_o <= `CIC_VEC_TOP - {11'h000, sel_reg, 1'b0};
				state_reg <= ST_IDLE;
			end
			ST_POP: begin
				// cc, a, x, pc in reverse order [RULE8]
				stack_pop_o <= 1'b1;
				stack_sel_o <= 2'h3 - cnt_reg;
				cnt_reg <= cnt_reg + 2'h1;
				if (cnt_reg == 2'h3) begin
					state_reg <= ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// condition code register
always @(posedge clk_sys_i) begin
	if (srst_i) begin
		cc_reg <= `CIC_CC_RST; // [RULE3]
	end else if (state_reg == ST_VEC) begin
		cc_reg[`CIC_CC_I_BIT] <= 1'b1; // [RULE6]
	end else if (state_reg == ST_POP && cnt_reg == 2'h3) begin
		cc_reg <= cpu_pop_cc_i; // [RULE8]
	end else if (cpu_halt_exec_i) begin
		cc_reg[`CIC_CC_I_BIT] <= 1'b0; // [RULE19]
	end else if (wr_go && wstrb0_reg && awaddr_reg == `CIC_OFS_CC) begin
		cc_reg <= wdata_reg;
	end
end

////////////////////////////////////////////////////////////////////////////////
// configuration, peripheral flags and clearing sequence
always @(posedge clk_sys_i) begin
	if (srst_i) begin
		enable_reg <= {NPER{1'b0}};
		extcfg_reg <= 4'h0;
		pinsel_reg <= {NPIN{1'b0}};
		flag_reg <= {NPER{1'b0}};
		armed_reg <= {NPER{1'b0}};
	end else begin
		if (wr_go && wstrb0_reg) begin
			case (awaddr_reg)
				`CIC_OFS_ENABLE: enable_reg <= wdata_reg[NPER-1:0];
				`CIC_OFS_EXTCFG: extcfg_reg <= wdata_reg[3:0]; // [RULE13]
				`CIC_OFS_PINSEL: pinsel_reg <= wdata_reg[NPIN-1:0];
				default: enable_reg <= enable_reg;
			endcase
		end
		// a status read arms every flag then set
		if (rd_go && s_axi_araddr == `CIC_OFS_PFLAG) begin
			armed_reg <= flag_reg;
		end else if ((rd_go && s_axi_araddr == `CIC_OFS_ASSOC)
			|| (wr_go && awaddr_reg == `CIC_OFS_ASSOC)) begin
			armed_reg <= {NPER{1'b0}};
		end
		// new flag wins; zero write or sequence clears the latch [RULE17] [RULE18]
		if (wr_go && wstrb0_reg && awaddr_reg == `CIC_OFS_PFLAG) begin
			flag_reg <= (flag_reg & wdata_reg[NPER-1:0]) | periph_flag_i;
		end else if ((rd_go && s_axi_araddr == `CIC_OFS_ASSOC)
			|| (wr_go && awaddr_reg == `CIC_OFS_ASSOC)) begin
			flag_reg <= (flag_reg & ~armed_reg) | periph_flag_i;
		end else begin
			flag_reg <= flag_reg | periph_flag_i;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// wake, events and interrupt line
always @* begin
	ev = 4'h0;
	ev[`CIC_EV_ENTRY] = (state_reg == ST_VEC);
	ev[`CIC_EV_RETURN] = (state_reg == ST_POP && cnt_reg == 2'h3);
	ev[`CIC_EV_WAKE] = ((cpu_wait_i && |all_pend) || (cpu_halt_i && |(all_pend & halt_cap)));
	ev[`CIC_EV_TRAP] = cpu_trap_i;
end
// sticky events, event mask and registered interrupt line
always @(posedge clk_sys_i) begin
	if (srst_i) begin
		istat_reg <= 4'h0;
		imask_reg <= 4'h0;
		wake_o <= 1'b0;
		mask_o <= 1'b1;
		irq_o <= 1'b0;
	end else begin
		// any source leaves wait, only capable ones leave halt [RULE10]
		wake_o <= ev[`CIC_EV_WAKE];
		mask_o <= i_bit;
		// set wins over the write-one clear
		if (wr_go && wstrb0_reg && awaddr_reg == `CIC_OFS_ISTAT) begin
			istat_reg <= (istat_reg & ~wdata_reg[3:0]) | ev;
		end else begin
			istat_reg <= istat_reg | ev;
		end
		if (wr_go && wstrb0_reg && awaddr_reg == `CIC_OFS_IMASK) begin
			imask_reg <= wdata_reg[3:0];
		end
		irq_o <= |(istat_reg & imask_reg);
	end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave
always @(posedge clk_sys_i) begin
	if (srst_i) begin
		aw_full_reg <= 1'b0;
		w_full_reg <= 1'b0;
		awaddr_reg <= 8'h00;
		wdata_reg <= 8'h00;
		wstrb0_reg <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `CIC_RESP_OKAY;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= `CIC_RESP_OKAY;
		s_axi_rdata <= 32'h00000000;
	end else begin
		// address and data taken in either order
		s_axi_awready <= ~aw_full_reg & ~(s_axi_awvalid & s_axi_awready);
		s_axi_wready <= ~w_full_reg & ~(s_axi_wvalid & s_axi_wready);
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg <= 1'b1;
			wdata_reg <= s_axi_wdata[7:0];
			wstrb0_reg <= s_axi_wstrb[0];
		end
		// response once both halves are held
		if (wr_go) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_reg <= `CIC_OFS_STATE && awaddr_reg[1:0] == 2'h0)
				? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		// single read, answered the cycle after acceptance
		s_axi_arready <= ~s_axi_rvalid & ~rd_go;
		if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_val};
			s_axi_rresp <= rd_ok ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end
endmodule // cic_core_interrupt_controller

// ==== hdl/cic_defines.vh ====
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH
// register byte offsets
`define CIC_OFS_CC 8'h00
`define CIC_OFS_ENABLE 8'h04
`define CIC_OFS_EXTCFG 8'h08
`define CIC_OFS_PINSEL 8'h0c
`define CIC_OFS_PFLAG 8'h10
`define CIC_OFS_ASSOC 8'h14
`define CIC_OFS_ISTAT 8'h18
`define CIC_OFS_IMASK 8'h1c
`define CIC_OFS_STATE 8'h20
// condition code layout and reset value
`define CIC_CC_I_BIT 3
`define CIC_CC_RST 8'h08
// external sensitivity codes, two bits per source
`define CIC_SENS_LOW 2'h0
`define CIC_SENS_RISE 2'h1
`define CIC_SENS_FALL 2'h2
`define CIC_SENS_BOTH 2'h3
// event bits of the sticky status register
`define CIC_EV_ENTRY 0
`define CIC_EV_RETURN 1
`define CIC_EV_WAKE 2
`define CIC_EV_TRAP 3
// highest vector address, trap vector
`define CIC_VEC_TOP 16'hfffc
// axi responses
`define CIC_RESP_OKAY 2'h0
`define CIC_RESP_SLVERR 2'h2
`endif

// ==== tb/cic_core_model.sv ====
`timescale 1ns/1ps
////////////////
// core stand-in: ends an instruction every other cycle, follows vector loads
module cic_core_model (
	// clock and reset
	input wire clk_sys_i,
	input wire srst_i,
	// from controller
	input wire vector_load_i,
	input wire [15:0] vector_addr_i,
	// to controller and bench
	output reg instr_done_o,
	output reg [15:0] pc_o,
	output reg [7:0] n_vec_o
);
	// instruction boundary pulse and handler fetch
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			instr_done_o <= 1'b0;
			pc_o <= 16'h0000;
			n_vec_o <= 8'h00;
		end else begin
			// entry can only start at an instruction end
			instr_done_o <= ~instr_done_o;
			// jump to the loaded vector
			if (vector_load_i) begin
				pc_o <= vector_addr_i;
				n_vec_o <= n_vec_o + 8'h01;
			end
		end
	end
endmodule // cic_core_model

// ==== tb/cic_checker.sv ====
`timescale 1ns/1ps
`include "cic_defines.vh"
////////////////
// entry, return and mask timing at the controller ports
module cic_checker (
	// clock and reset
	input wire clk_sys_i,
	input wire srst_i,
	// core handshake
	input wire cpu_instr_done_i,
	input wire cpu_trap_i,
	input wire cpu_halt_exec_i,
	input wire [7:0] cpu_pop_cc_i,
	// core control
	input wire stack_push_o,
	input wire stack_pop_o,
	input wire [1:0] stack_sel_o,
	input wire vector_load_o,
	input wire [15:0] vector_addr_o,
	input wire mask_o
);
	// mask bit of the popped condition code
	wire pop_mask = cpu_pop_cc_i[`CIC_CC_I_BIT];
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	AST_RST_MASK: assert property ($fell(srst_i) |-> mask_o)
		else $error("mask clear after reset");
	AST_ENTRY_END: assert property ($rose(stack_push_o) |-> $past(cpu_instr_done_i, 2))
		else $error("entry began inside an instruction");
	AST_PUSH_ORDER: assert property ($rose(stack_push_o) |-> stack_sel_o == 2'h0
		##1 (stack_push_o && stack_sel_o == 2'h1) ##1 (stack_push_o && stack_sel_o == 2'h2)
		##1 (stack_push_o && stack_sel_o == 2'h3) ##1 (vector_load_o && !stack_push_o))
		else $error("push order or vector load wrong");
	AST_MASK_SET: assert property (vector_load_o |=> mask_o)
		else $error("mask not set on entry");
	AST_TRAP_VEC: assert property (cpu_trap_i |->
		##[1:16] (vector_load_o && vector_addr_o == `CIC_VEC_TOP)) else $error("trap vector wrong");
	AST_MASKABLE: assert property (vector_load_o && vector_addr_o != `CIC_VEC_TOP |->
		!$past(mask_o, 5)) else $error("maskable entry while masked");
	AST_POP_ORDER: assert property ($rose(stack_pop_o) |-> stack_sel_o == 2'h3
		##1 (stack_pop_o && stack_sel_o == 2'h2) ##1 (stack_pop_o && stack_sel_o == 2'h1)
		##1 (stack_pop_o && stack_sel_o == 2'h0)) else $error("pop order wrong");
	AST_RET_MASK: assert property (stack_pop_o && stack_sel_o == 2'h0 |=>
		mask_o == $past(pop_mask, 2)) else $error("mask not restored");
	AST_HALT_CLR: assert property (cpu_halt_exec_i ##1 (!vector_load_o && !stack_pop_o) |=>
		!mask_o) else $error("halt left mask set");
	// main scenarios
	COV_TRAP: cover property (vector_load_o && vector_addr_o == `CIC_VEC_TOP);
	COV_RET: cover property ($rose(stack_pop_o));
	COV_HALT: cover property (cpu_halt_exec_i ##1 !mask_o);
endmodule // cic_checker
bind cic_core_interrupt_controller cic_checker u_cic_checker (.clk_sys_i(clk_sys_i),
	.srst_i(srst_i), .cpu_instr_done_i(cpu_instr_done_i), .cpu_trap_i(cpu_trap_i),
	.cpu_halt_exec_i(cpu_halt_exec_i), .cpu_pop_cc_i(cpu_pop_cc_i), .stack_push_o(stack_push_o),
	.stack_pop_o(stack_pop_o), .stack_sel_o(stack_sel_o), .vector_load_o(vector_load_o),
	.vector_addr_o(vector_addr_o), .mask_o(mask_o));

// ==== tb/cic_core_interrupt_controller_test.sv ====
`timescale 1ns/1ps
`include "cic_defines.vh"
////////////////
// register, entry, return and wake sequences against the core stand-in
module cic_core_interrupt_controller_test;
	// design inputs
	reg clk_sys_i = 1'b0;
	reg srst_i = 1'b1;
	reg trap = 1'b0, handler_return_instruction = 1'b0, hexe = 1'b0, wt = 1'b0, hl = 1'b0, ext = 1'b1;
	reg [7:0] pcc = 8'h00;
	reg [3:0] pf = 4'h0, np = 4'hf;
	reg [7:0] awaddr = 8'h00, araddr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	// design outputs
	wire awready, wready, bvalid, arready, rvalid, push, pop, vl, wake, mask, irq, done;
	wire [1:0] bresp, rresp, sel;
	wire [31:0] rdata;
	wire [15:0] va, pc;
	wire [7:0] n_vec;
	// bookkeeping
	integer n_errors = 0, comparisons = 0;
	reg [31:0] d;
	reg [1:0] r;
	reg i0;
	always #2 clk_sys_i = ~clk_sys_i;
	cic_core_interrupt_controller #(.NPER(4), .NPIN(4), .HALT_PER_MASK(4'h0))
		u_cic_core_interrupt_controller (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.cpu_instr_done_i(done), .cpu_trap_i(trap), .cpu_handler_return_instruction_i(handler_return_instruction), .cpu_halt_exec_i(hexe),
		.cpu_wait_i(wt), .cpu_halt_i(hl), .cpu_pop_cc_i(pcc), .periph_flag_i(pf),
		.nand_pins_i(np), .external_request_source_i(ext), .stack_push_o(push),
		.stack_pop_o(pop), .stack_sel_o(sel), .vector_load_o(vl), .vector_addr_o(va),
		.wake_o(wake), .mask_o(mask), .irq_o(irq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	cic_core_model u_cic_core_model (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.vector_load_i(vl), .vector_addr_i(va), .instr_done_o(done), .pc_o(pc), .n_vec_o(n_vec));
	////////////////
	// verdict and run end
	task finish_test;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, n_errors);
			if (n_errors == 0 && comparisons > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// single comparison
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				$display("MISMATCH %s exp %h got %h", nm, e, g);
				n_errors = n_errors + 1;
			end
		end
	endtask
	// a bound that ran out ends the run
	task tmo(input integer i);
		if (i >= 64) begin
			chk("wait bound", 0, 1);
			finish_test;
		end
	endtask
	// write: address and data offered together, released as each is taken
	task axi_wr(input [7:0] a, input [31:0] v);
		integer i;
		reg aw, w;
		begin
			aw = 1'b1;
			w = 1'b1;
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			for (i = 0; i < 64 && (aw || w); i = i + 1) begin
				@(posedge clk_sys_i);
				aw = aw && awready !== 1'b1;
				w = w && wready !== 1'b1;
				awvalid <= aw;
				wvalid <= w;
			end
			tmo(i);
			i = 0;
			do begin @(posedge clk_sys_i); i = i + 1; end while (bvalid !== 1'b1 && i < 64);
			tmo(i);
			r = bresp;
			bready <= 1'b0;
			// one idle edge before the next request
			@(posedge clk_sys_i);
		end
	endtask
	// read: data and response taken at the rvalid edge
	task axi_rd(input [7:0] a, output [31:0] v, output [1:0] rs);
		integer i;
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			i = 0;
			do begin @(posedge clk_sys_i); i = i + 1; end while (arready !== 1'b1 && i < 64);
			arvalid <= 1'b0;
			do begin @(posedge clk_sys_i); i = i + 1; end while (rvalid !== 1'b1 && i < 64);
			tmo(i);
			v = rdata;
			rs = rresp;
			rready <= 1'b0;
			@(posedge clk_sys_i);
		end
	endtask
	task rchk(input [7:0] a, input [31:0] e, input string nm);
		begin
			axi_rd(a, d, r);
			chk(nm, e, d);
			chk("read resp", `CIC_RESP_OKAY, r);
		end
	endtask
	// one-cycle peripheral flag pulse
	task pulse_pf(input [3:0] v);
		begin
			pf <= v;
			@(posedge clk_sys_i);
			pf <= 4'h0;
		end
	endtask
	// wait for a vector load, then compare the fetched address
	task wvec(input [15:0] e, input string nm);
		integer i;
		reg [7:0] n0;
		begin
			n0 = n_vec;
			for (i = 0; i < 64 && n_vec === n0; i = i + 1)
				@(posedge clk_sys_i);
			tmo(i);
			repeat (3) @(posedge clk_sys_i);
			chk(nm, e, pc);
			chk("mask in handler", 1, mask);
		end
	endtask
	// no entry may happen for a while
	task nov(input string nm);
		reg [7:0] n0;
		begin
			n0 = n_vec;
			repeat (30) @(posedge clk_sys_i);
			chk(nm, n0, n_vec);
		end
	endtask
	// return: four pops, mask from the popped byte
	task ret(input [7:0] cc);
		begin
			pcc <= cc;
			handler_return_instruction <= 1'b1;
			@(posedge clk_sys_i);
			handler_return_instruction <= 1'b0;
			repeat (6) @(posedge clk_sys_i);
			chk("mask after return", cc[`CIC_CC_I_BIT], mask);
		end
	endtask
	////////////////
	// main sequence
	initial begin
		repeat (6) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		rchk(`CIC_OFS_CC, `CIC_CC_RST, "cc reset");
		chk("mask reset", 1, mask);
		axi_rd(8'h24, d, r);
		chk("unmapped resp", `CIC_RESP_SLVERR, r);
		axi_wr(8'h24, 32'h000000ff);
		chk("unmapped write resp", `CIC_RESP_SLVERR, r);
		axi_wr(`CIC_OFS_EXTCFG, 32'h09);
		chk("write resp", `CIC_RESP_OKAY, r);
		axi_wr(`CIC_OFS_PINSEL, 32'h03);
		$display("test reset done");
		axi_wr(`CIC_OFS_ENABLE, 32'h02);
		pulse_pf(4'h2);
		nov("entry while masked");
		rchk(`CIC_OFS_PFLAG, 32'h02, "flag held");
		axi_wr(`CIC_OFS_CC, 32'h00);
		wvec(16'hfff4, "periph1 vector");
		axi_wr(`CIC_OFS_PFLAG, 32'h00);
		ret(8'h00);
		nov("entry after zero write");
		$display("test peripheral done");
		axi_wr(`CIC_OFS_CC, 32'h08);
		axi_wr(`CIC_OFS_ENABLE, 32'h05);
		pulse_pf(4'hd);
		axi_wr(`CIC_OFS_CC, 32'h00);
		wvec(16'hfff6, "priority vector");
		rchk(`CIC_OFS_PFLAG, 32'h0d, "flags armed");
		axi_rd(`CIC_OFS_ASSOC, d, r);
		rchk(`CIC_OFS_PFLAG, 32'h00, "flags after sequence");
		ret(8'h00);
		axi_wr(`CIC_OFS_ENABLE, 32'h0f);
		nov("dropped pending");
		$display("test clear sequence done");
		axi_wr(`CIC_OFS_CC, 32'h08);
		trap <= 1'b1;
		@(posedge clk_sys_i);
		trap <= 1'b0;
		wvec(`CIC_VEC_TOP, "trap vector");
		ret(8'h08);
		ext <= 1'b0;
		nov("external while masked");
		axi_wr(`CIC_OFS_CC, 32'h00);
		wvec(16'hfff8, "external vector");
		ret(8'h00);
		nov("edge latch cleared");
		np <= 4'hc;
		repeat (8) @(posedge clk_sys_i);
		np <= 4'he;
		nov("low pin blocks");
		np <= 4'hf;
		wvec(16'hfffa, "combined vector");
		ret(8'h00);
		$display("test trap and external done");
		axi_wr(`CIC_OFS_CC, 32'h08);
		hl <= 1'b1;
		pulse_pf(4'h2);
		repeat (6) @(posedge clk_sys_i);
		chk("halt wake by peripheral", 0, wake);
		ext <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		ext <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		chk("halt wake by external", 1, wake);
		hl <= 1'b0;
		wt <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		chk("wait wake", 1, wake);
		wt <= 1'b0;
		axi_wr(`CIC_OFS_PFLAG, 32'h00);
		hexe <= 1'b1;
		@(posedge clk_sys_i);
		hexe <= 1'b0;
		wvec(16'hfff8, "halt pending entry");
		ret(8'h00);
		axi_wr(`CIC_OFS_EXTCFG, 32'h0d);
		ext <= 1'b1;
		wvec(16'hfff8, "both edges vector");
		ret(8'h00);
		rchk(`CIC_OFS_ISTAT, 32'h0f, "event status");
		axi_wr(`CIC_OFS_IMASK, 32'h00);
		i0 = irq;
		axi_wr(`CIC_OFS_IMASK, 32'hff);
		chk("irq follows mask", 1, i0 ^ irq);
		axi_wr(`CIC_OFS_ISTAT, 32'h0f);
		rchk(`CIC_OFS_ISTAT, 32'h00, "status cleared");
		chk("irq after clear", 0, irq);
		$display("test wake and status done");
		finish_test;
	end
endmodule // cic_core_interrupt_controller_test
